// File: common/mei_defs.svh
`ifndef MEI_DEFS_SVH
`define MEI_DEFS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define MEI_REG_TR_FIRST   8'h00
`define MEI_REG_TR_SECOND  8'h04
`define MEI_REG_BASE       8'h08
`define MEI_REG_STATUS     8'h0c
`define MEI_SLOT_REGION    2'h1
`define MEI_SLOTS          16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MEI_US_NS          1000
`define MEI_CLK_NS         10
`define MEI_US_CYCLES      (`MEI_US_NS / `MEI_CLK_NS)
`define MEI_US_CNT_W       7
`define MEI_WAIT_FULL      9'h100

// ----------------------------------------------------------------
// storage marks, steps and alignment
// ----------------------------------------------------------------
`define MEI_MARK_HI        8'hf0
`define MEI_MARK_LO        8'h0f
`define MEI_MARK_ALL       8'hff
`define MEI_DW_STEP        24'h000008
`define MEI_W_STEP         24'h000004
`define MEI_DW_MASK        24'hfffff8
`define MEI_ALIGN_DW_DEC   3'h7
`define MEI_ALIGN_W_DEC    3'h3
`define MEI_WORD_SEL       2
`define MEI_COUNT_ONE      9'h001
`define MEI_COUNT_TWO      9'h002

// ----------------------------------------------------------------
// field positions inside a storage word
// ----------------------------------------------------------------
`define MEI_LOG_HI         22
`define MEI_LOG_LO         12
`define MEI_SLOT_HI        22
`define MEI_SLOT_LO        19
`define MEI_UNUSED_HI      11
`define MEI_UNUSED_LO      8
`define MEI_PAR_HI         15

`endif

// File: common/mei_pkg.sv
package mei_pkg;

	typedef enum logic [2:0] {
		insert_translator_instr,
		timed_wait_instr,
		store_pref_base_instr,
		load_pref_base_instr,
		word_copy_instr
	} op_t;

	typedef enum logic [2:0] {
		exc_none,
		exc_spec,
		exc_priv,
		exc_prot,
		exc_addr,
		exc_intr,
		exc_unsup
	} exc_t;

	typedef enum {
		st_idle,
		st_ins_second,
		st_ins_first,
		st_waiting,
		st_sb_store,
		st_lb_fetch,
		st_lb_valid,
		st_mv_first,
		st_mv_check,
		st_mv_store,
		st_mv_fetch
	} state_t;

	typedef struct packed {
		logic        valid;
		op_t         op;
		logic [3:0]  first_reg_field;
		logic [3:0]  second_reg_field;
		logic [7:0]  imm;
		logic [23:0] addr1;
		logic [23:0] addr2;
		logic        problem_state;
	} instr_t;

	typedef struct packed {
		logic done;
		exc_t exc;
	} done_t;

	typedef struct packed {
		logic        we;
		logic [3:0]  idx;
		logic [31:0] data;
		logic        hi_byte_only;
	} gr_wr_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [23:0] addr;
		logic [63:0] wdata;
		logic [7:0]  mark;
	} mem_req_t;

	typedef struct packed {
		logic        ack;
		logic [63:0] rdata;
		logic        invalid;
		logic        prot_err;
		logic        addr_err;
	} mem_rsp_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} bus_req_t;

endpackage : mei_pkg

// File: hw/align_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "mei_defs.svh"

module align_check
(
	input  wire logic [2:0] low_bits,
	output logic            on_dw,
	output logic            on_word,
	output logic            bad
);
	logic [2:0] dec;

	// decrement first, then only 7 and 3 are legal
	assign dec     = low_bits - 3'h1;
	assign on_dw   = (dec == `MEI_ALIGN_DW_DEC);
	assign on_word = (dec == `MEI_ALIGN_W_DEC);
	assign bad     = !(on_dw || on_word);
endmodule : align_check
`default_nettype wire

// File: hw/multi_element_instr_exec.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mei_defs.svh"

// What this block does
// - second translation register into general register byte 0
// - then first translation register into other register
// - count microseconds to 256, decrement value, repeat
// - wait ends when remaining value reaches zero
// - other pending interrupt ends wait at the tick, before increment
// - timer update serviced, wait resumes
// - base store word: fields placed, gaps zero
// - base store: alignment and privilege exceptions
// - marks from address bit 29, store, compare
// - base load: alignment and privilege exceptions
// - zero unused nibble, regenerate byte parity
// - validate new base; invalid means specification error
// - load logical base, physical from slot
// - copy left to right, length plus one words
// - doubleword aligned storage traffic, alignment cases
// - detect overlap, flag it, replicate without refetch
// - first source doubleword fetched before checking
// - low bits decremented to 7 or 3
// - zero count stores only first word
// - overlapped path stores held doubleword repeatedly
// - protection and addressing errors reported
// - slot replaces logical address bits 9-12
module multi_element_instr_exec
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire mei_pkg::instr_t   instr,
	output var  logic              busy_q,
	output var  mei_pkg::done_t    done_q,
	output var  mei_pkg::gr_wr_t   gr_wr_q,
	output var  mei_pkg::mem_req_t mem_req_q,
	input  wire mei_pkg::mem_rsp_t mem_rsp,
	input  wire logic              int_other_pending,
	input  wire logic              int_timer_pending,
	output var  logic              timer_service_q,
	output var  logic              asc_check_q,
	input  wire mei_pkg::bus_req_t bus,
	output var  logic [31:0]       bus_rdata_q
);
	import mei_pkg::*;

	state_t      state_q;
	instr_t      cur_q;
	logic [31:0] tr_first_q;
	logic [7:0]  tr_second_q;
	logic [3:0]  slot_q [`MEI_SLOTS];
	logic [10:0] base_log_q;
	logic [3:0]  base_phys_q;
	logic [8:0]  fcnt_q;
	logic [7:0]  nval_q;
	logic [23:0] src_q;
	logic [23:0] dst_q;
	logic [8:0]  rem_q;
	logic [31:0] s_q;
	logic [31:0] t_q;
	logic [31:0] work_q;
	logic        work_par_q;
	logic        overlap_q;
	exc_t        last_exc_q;

	// ----------------------------------------------------------------
	// decoding and selection
	// ----------------------------------------------------------------
	logic        tick;
	logic        src_dw;
	logic        src_w;
	logic        src_bad;
	logic        dst_dw;
	logic        dst_w;
	logic        dst_bad;
	logic        mem_fault;
	exc_t        fault_exc;
	logic [8:0]  fcnt_inc;
	logic [7:0]  nval_dec;
	logic        rem_last;
	logic [8:0]  rem_next;
	logic [7:0]  copy_mark;
	logic [31:0] fetched_word;
	logic [31:0] base_word;
	logic [31:0] fixed_word;
	logic        slot_hit;
	logic [31:0] rd_word;

	assign mem_fault    = mem_rsp.ack && (mem_rsp.prot_err || mem_rsp.addr_err);
	assign fault_exc    = mem_rsp.prot_err ? exc_prot : exc_addr;
	assign fcnt_inc     = fcnt_q + 9'h001;
	assign nval_dec     = nval_q - 8'h01;
	assign rem_last     = (rem_q == `MEI_COUNT_ONE);
	assign rem_next     = rem_last ? 9'h000 : rem_q - `MEI_COUNT_TWO;
	assign copy_mark    = rem_last ? `MEI_MARK_HI : `MEI_MARK_ALL;
	assign fetched_word = cur_q.addr1[`MEI_WORD_SEL] ? mem_rsp.rdata[31:0] : mem_rsp.rdata[63:32];
	// logical base at word bits 9-19, physical at 28-31, rest zero
	assign base_word    = {9'h000, base_log_q, 8'h00, base_phys_q};
	// unused nibble forced to zero before the value is used
	assign fixed_word   = {fetched_word[31:`MEI_UNUSED_HI+1], 4'h0, fetched_word[`MEI_UNUSED_LO-1:0]};
	assign slot_hit     = (bus.addr[7:6] == `MEI_SLOT_REGION);

	us_tick u_tick
	(
		.clk_sys (clk_sys),
		.reset   (reset),
		.run     (state_q == st_waiting),
		.tick    (tick)
	);

	align_check u_src_align
	(
		.low_bits (src_q[2:0]),
		.on_dw    (src_dw),
		.on_word  (src_w),
		.bad      (src_bad)
	);

	align_check u_dst_align
	(
		.low_bits (dst_q[2:0]),
		.on_dw    (dst_dw),
		.on_word  (dst_w),
		.bad      (dst_bad)
	);

	// logical to physical address through the slot table
	function automatic mem_req_t mk_req(input logic we, input logic [23:0] a,
		input logic [63:0] d, input logic [7:0] m);
		mem_req_t r;
		r.req   = 1'b1;
		r.we    = we;
		r.addr  = {a[23], slot_q[a[`MEI_SLOT_HI:`MEI_SLOT_LO]], a[`MEI_SLOT_LO-1:0]};
		r.wdata = d;
		r.mark  = m;
		return r;
	endfunction : mk_req

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	assign rd_word = slot_hit ? {28'h0000000, slot_q[bus.addr[5:2]]} :
		(bus.addr == `MEI_REG_TR_FIRST)  ? tr_first_q :
		(bus.addr == `MEI_REG_TR_SECOND) ? {24'h000000, tr_second_q} :
		(bus.addr == `MEI_REG_BASE)      ? {17'h00000, base_log_q, base_phys_q} :
		(bus.addr == `MEI_REG_STATUS)    ? {27'h0000000, overlap_q, busy_q, last_exc_q} :
		32'h00000000;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			bus_rdata_q <= '0;
		else
			bus_rdata_q <= bus.rd ? rd_word : 32'h00000000;
	end

	// translation registers written by software
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			tr_first_q  <= '0;
			tr_second_q <= '0;
		end
		else if (bus.wr && bus.addr == `MEI_REG_TR_FIRST)
			tr_first_q <= bus.wdata;
		else if (bus.wr && bus.addr == `MEI_REG_TR_SECOND)
			tr_second_q <= bus.wdata[7:0];
	end

	// slot table, one flop group per entry
	for (genvar gi = 0; gi < `MEI_SLOTS; gi++)
	begin : g_slot
		always_ff @(posedge clk_sys or posedge reset)
		begin
			if (reset)
				slot_q[gi] <= 4'(gi);
			else if (bus.wr && slot_hit && bus.addr[5:2] == 4'(gi))
				slot_q[gi] <= bus.wdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	task automatic finish(input exc_t e);
		done_q     <= '{done: 1'b1, exc: e};
		last_exc_q <= e;
		busy_q     <= 1'b0;
		state_q    <= st_idle;
	endtask : finish

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_q <= st_idle; cur_q <= '0; busy_q <= 1'b0; done_q <= '0;
			gr_wr_q <= '0; mem_req_q <= '0; timer_service_q <= 1'b0; asc_check_q <= 1'b0;
			base_log_q <= '0; base_phys_q <= '0; fcnt_q <= '0; nval_q <= '0;
			src_q <= '0; dst_q <= '0; rem_q <= '0; s_q <= '0; t_q <= '0;
			work_q <= '0; work_par_q <= 1'b0; overlap_q <= 1'b0; last_exc_q <= exc_none;
		end
		else
		begin
			done_q          <= '0;
			gr_wr_q.we      <= 1'b0;
			timer_service_q <= 1'b0;
			asc_check_q     <= 1'b0;
			if (mem_rsp.ack)
				mem_req_q.req <= 1'b0;
			unique case (state_q)
			st_idle:
				if (instr.valid)
				begin
					cur_q  <= instr;
					busy_q <= 1'b1;
					src_q  <= instr.addr2;
					dst_q  <= instr.addr1;
					unique case (instr.op)
					insert_translator_instr:
						state_q <= st_ins_second;
					timed_wait_instr:
						if (instr.imm == 8'h00)
							finish(exc_none);
						else
						begin
							fcnt_q  <= '0;
							nval_q  <= instr.imm;
							state_q <= st_waiting;
						end
					store_pref_base_instr:
						if (instr.problem_state)
							finish(exc_priv);
						else if (instr.addr1[1:0] != 2'h0)
							finish(exc_spec);
						else
						begin
							mem_req_q <= mk_req(1'b1, instr.addr1 & `MEI_DW_MASK, {base_word, base_word},
								instr.addr1[`MEI_WORD_SEL] ? `MEI_MARK_LO : `MEI_MARK_HI);
							state_q   <= st_sb_store;
						end
					load_pref_base_instr:
						if (instr.problem_state)
							finish(exc_priv);
						else if (instr.addr1[1:0] != 2'h0)
							finish(exc_spec);
						else
						begin
							mem_req_q <= mk_req(1'b0, instr.addr1 & `MEI_DW_MASK, '0, `MEI_MARK_ALL);
							state_q   <= st_lb_fetch;
						end
					word_copy_instr:
					begin
						rem_q     <= {1'b0, instr.imm} + `MEI_COUNT_ONE;
						mem_req_q <= mk_req(1'b0, instr.addr2 & `MEI_DW_MASK, '0, `MEI_MARK_ALL);
						state_q   <= st_mv_first;
					end
					endcase
				end
			st_ins_second:
			begin
				gr_wr_q <= '{we: 1'b1, idx: cur_q.second_reg_field, data: {tr_second_q, 24'h000000},
					hi_byte_only: 1'b1};
				state_q <= st_ins_first;
			end
			st_ins_first:
			begin
				gr_wr_q <= '{we: 1'b1, idx: cur_q.first_reg_field, data: tr_first_q,
					hi_byte_only: 1'b0};
				finish(exc_none);
			end
			st_waiting:
				if (tick)
				begin
					timer_service_q <= int_timer_pending && !int_other_pending;
					if (int_other_pending)
						finish(exc_intr);
					else if (fcnt_inc == `MEI_WAIT_FULL)
					begin
						nval_q <= nval_dec;
						fcnt_q <= '0;
						if (nval_dec == 8'h00)
							finish(exc_none);
					end
					else
						fcnt_q <= fcnt_inc;
				end
			st_sb_store:
				if (mem_fault)
					finish(fault_exc);
				else if (mem_rsp.ack)
				begin
					asc_check_q <= 1'b1;
					finish(exc_none);
				end
			st_lb_fetch:
				if (mem_fault)
					finish(fault_exc);
				else if (mem_rsp.ack)
				begin
					work_q     <= fixed_word;
					work_par_q <= ^fixed_word[`MEI_PAR_HI:`MEI_UNUSED_LO];
					mem_req_q  <= mk_req(1'b0, fixed_word[23:0] & `MEI_DW_MASK, '0, `MEI_MARK_ALL);
					state_q    <= st_lb_valid;
				end
			st_lb_valid:
				if (mem_rsp.ack && mem_rsp.invalid)
					finish(exc_spec);
				else if (mem_rsp.ack)
				begin
					base_log_q  <= work_q[`MEI_LOG_HI:`MEI_LOG_LO];
					base_phys_q <= slot_q[work_q[`MEI_SLOT_HI:`MEI_SLOT_LO]];
					finish(exc_none);
				end
			st_mv_first:
				if (mem_fault)
					finish(fault_exc);
				else if (mem_rsp.ack)
				begin
					s_q     <= mem_rsp.rdata[63:32];
					t_q     <= mem_rsp.rdata[31:0];
					state_q <= st_mv_check;
				end
			st_mv_check:
			begin
				overlap_q <= (dst_q == src_q + `MEI_W_STEP) || (dst_q == src_q + `MEI_DW_STEP);
				if (src_bad || dst_bad)
					finish(exc_spec);
				else if (!(src_dw && dst_dw))
					finish(exc_unsup);
				else
				begin
					mem_req_q <= mk_req(1'b1, dst_q, {s_q, t_q}, copy_mark);
					rem_q     <= rem_next;
					state_q   <= st_mv_store;
				end
			end
			st_mv_store:
				if (mem_fault)
					finish(fault_exc);
				else if (mem_rsp.ack)
				begin
					dst_q <= dst_q + `MEI_DW_STEP;
					if (rem_q == 9'h000)
						finish(exc_none);
					else if (overlap_q)
					begin
						mem_req_q <= mk_req(1'b1, dst_q + `MEI_DW_STEP, {s_q, t_q}, copy_mark);
						rem_q     <= rem_next;
					end
					else
					begin
						src_q     <= src_q + `MEI_DW_STEP;
						mem_req_q <= mk_req(1'b0, src_q + `MEI_DW_STEP, '0, `MEI_MARK_ALL);
						state_q   <= st_mv_fetch;
					end
				end
			st_mv_fetch:
				if (mem_fault)
					finish(fault_exc);
				else if (mem_rsp.ack)
				begin
					s_q       <= mem_rsp.rdata[63:32];
					t_q       <= mem_rsp.rdata[31:0];
					mem_req_q <= mk_req(1'b1, dst_q, mem_rsp.rdata, copy_mark);
					rem_q     <= rem_next;
					state_q   <= st_mv_store;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_ins_second_byte: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_ins_second |=> gr_wr_q.we && gr_wr_q.hi_byte_only
			&& gr_wr_q.idx == cur_q.second_reg_field && gr_wr_q.data[23:0] == 24'h000000)
		else $error("second translation register write wrong");

	chk_ins_first_word: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_ins_second |=> ##1 gr_wr_q.we && !gr_wr_q.hi_byte_only
			&& gr_wr_q.data == $past(tr_first_q) && done_q.done && done_q.exc == exc_none)
		else $error("first translation register write wrong");

	chk_wait_bound: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_waiting |-> fcnt_q < `MEI_WAIT_FULL)
		else $error("wait counter passed its limit");

	chk_wait_intr_end: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_waiting && tick && int_other_pending |=> done_q.done && done_q.exc == exc_intr)
		else $error("pending interrupt did not end the wait");

	chk_timer_resume: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_waiting && tick && int_timer_pending && !int_other_pending
			&& fcnt_inc != `MEI_WAIT_FULL |=> state_q == st_waiting && timer_service_q)
		else $error("timer update did not resume the wait");

	chk_base_word_gaps: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_sb_store && mem_req_q.req |-> mem_req_q.we
			&& mem_req_q.wdata[31:23] == 9'h000 && mem_req_q.wdata[11:4] == 8'h00)
		else $error("base store word has nonzero gaps");

	chk_priv_refused: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_idle && instr.valid && instr.op == store_pref_base_instr && instr.problem_state
			|=> done_q.done && done_q.exc == exc_priv && !mem_req_q.req)
		else $error("problem state base store not refused");

	chk_base_fixed: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_lb_valid |-> work_q[11:8] == 4'h0 && work_par_q == ^work_q[15:8])
		else $error("working byte not cleaned");

	chk_invalid_keeps: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_lb_valid && mem_rsp.ack && mem_rsp.invalid
			|=> done_q.exc == exc_spec && $stable(base_log_q) && $stable(base_phys_q))
		else $error("invalid base value was loaded");

	chk_copy_dw_only: assert property (@(posedge clk_sys) disable iff (reset)
		mem_req_q.req && cur_q.op == word_copy_instr |-> mem_req_q.addr[2:0] == 3'h0)
		else $error("copy traffic not doubleword aligned");

	chk_overlap_nofetch: assert property (@(posedge clk_sys) disable iff (reset)
		state_q == st_mv_store && overlap_q && mem_req_q.req |-> mem_req_q.we)
		else $error("overlapped copy fetched source");
endmodule : multi_element_instr_exec
`default_nettype wire

// File: hw/us_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "mei_defs.svh"

module us_tick
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic run,
	output logic      tick
);
	logic [`MEI_US_CNT_W-1:0] cnt_q;

	// one pulse per microsecond while running
	assign tick = run && (cnt_q == `MEI_US_CNT_W'(`MEI_US_CYCLES - 1));

	// ----------------------------------------------------------------
	// cycle counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			cnt_q <= '0;
		else if (!run || tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + `MEI_US_CNT_W'(1);
	end
endmodule : us_tick
`default_nettype wire

// File: verification/storage_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// doubleword storage behind the block's memory port
// ----------------------------------------------------------------
module storage_model
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire mei_pkg::mem_req_t mem_req,
	input  wire logic              slow,
	input  wire logic [23:0]       bad_addr,
	output var  mei_pkg::mem_rsp_t mem_rsp,
	output var  logic [23:0]       last_addr,
	output var  logic [7:0]        last_mark,
	output var  logic [7:0]        reads
);
	import mei_pkg::*;

	logic [63:0] mem [int];
	logic [63:0] word;
	logic [2:0]  wait_q;
	logic        go;
	int          k;

	// answer only after the request was seen, never twice for one request
	assign go = mem_req.req && !mem_rsp.ack && wait_q >= (slow ? 3'h3 : 3'h0);

	// serve one doubleword; released read data flips every cycle
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			mem_rsp <= '0;
			wait_q <= 3'h0;
			reads <= 8'h0;
		end
		else
		begin
			k = int'(mem_req.addr[23:3]);
			word = mem.exists(k) ? mem[k] : 64'h0;
			mem_rsp.ack <= go;
			mem_rsp.invalid <= go && !mem_req.we && mem_req.addr == bad_addr;
			mem_rsp.prot_err <= go && mem_req.we && mem_req.addr == bad_addr;
			mem_rsp.addr_err <= go && mem_req.addr[23]; // top address bit lies beyond installed storage
			mem_rsp.rdata <= go ? word : ~mem_rsp.rdata;
			wait_q <= (mem_req.req && !go && !mem_rsp.ack) ? wait_q + 3'h1 : 3'h0;
			if (go)
			begin
				last_addr <= mem_req.addr;
				last_mark <= mem_req.mark;
				reads <= reads + {7'h0, !mem_req.we};
				for (int j = 0; j < 8; j++)
					if (mem_req.we && mem_req.mark[j])
						word[8*j +: 8] = mem_req.wdata[8*j +: 8];
				mem[k] = word;
			end
		end
	end
endmodule : storage_model

`default_nettype wire

// File: verification/tb_multi_element_instr_exec.sv
`timescale 1ns/1ps
`default_nettype none

module tb_multi_element_instr_exec;
	import mei_pkg::*;

	logic        clk_sys;
	logic        reset;
	instr_t      instr;
	logic        busy_q;
	done_t       done_q;
	gr_wr_t      gr_wr_q;
	mem_req_t    mem_req_q;
	mem_rsp_t    mem_rsp;
	logic        int_other_pending;
	logic        int_timer_pending;
	logic        timer_service_q;
	logic        asc_check_q;
	bus_req_t    bus;
	logic [31:0] bus_rdata_q;
	logic        slow;
	logic [23:0] bad_addr;
	logic [23:0] last_addr;
	logic [7:0]  last_mark;
	logic [7:0]  reads;
	logic [7:0]  r0;
	logic [31:0] rd;
	gr_wr_t      gw [2];
	exc_t        exc;
	int          errors;
	int          comparisons;
	int          cyc;
	int          services;
	int          ascs;
	int          ngw;

	multi_element_instr_exec multi_element_instr_exec_inst (.clk_sys(clk_sys), .reset(reset), .instr(instr),
		.busy_q(busy_q), .done_q(done_q), .gr_wr_q(gr_wr_q), .mem_req_q(mem_req_q), .mem_rsp(mem_rsp),
		.int_other_pending(int_other_pending), .int_timer_pending(int_timer_pending),
		.timer_service_q(timer_service_q), .asc_check_q(asc_check_q), .bus(bus), .bus_rdata_q(bus_rdata_q));

	storage_model storage_model_inst (.clk_sys(clk_sys), .reset(reset), .mem_req(mem_req_q), .slow(slow),
		.bad_addr(bad_addr), .mem_rsp(mem_rsp), .last_addr(last_addr), .last_mark(last_mark), .reads(reads));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus <= '0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk_sys);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		rd = bus_rdata_q;
	endtask : bus_rd

	// issue one instruction, then watch outputs until done under a bound
	task automatic run(input op_t op, input logic [7:0] imm, input logic [23:0] a1, input logic [23:0] a2,
		input logic ps);
		@(posedge clk_sys);
		instr <= '{valid: 1'b1, op: op, first_reg_field: 4'h3, second_reg_field: 4'h9, imm: imm,
			addr1: a1, addr2: a2, problem_state: ps};
		@(posedge clk_sys);
		instr.valid <= 1'b0;
		services = 0;
		ascs = 0;
		ngw = 0;
		for (cyc = 1; cyc < 30000; cyc++)
		begin
			#1;
			services += int'(timer_service_q);
			ascs += int'(asc_check_q);
			if (gr_wr_q.we === 1'b1 && ngw < 2)
			begin
				gw[ngw] = gr_wr_q;
				ngw++;
			end
			if (cyc == 1 && done_q.done !== 1'b1)
				chk(busy_q, 1'b1);
			if (done_q.done === 1'b1)
			begin
				exc = done_q.exc;
				chk(busy_q, 1'b0);
				return;
			end
			@(posedge clk_sys);
		end
		errors++;
		conclude();
	endtask : run

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		bus_wr(8'h80, 32'hffff_ffff);
		bus_rd(8'h80);
		chk(rd, 32'h0);
		bus_wr(8'h08, 32'hffff_ffff);
		bus_rd(8'h08);
		chk(rd, 32'h0);
		bus_rd(8'h44);
		chk(rd, 32'h1);
	endtask : t_regs

	task automatic t_insert;
		bus_wr(8'h00, 32'h1234_5678);
		bus_wr(8'h04, 32'hffff_ffa5);
		bus_rd(8'h04);
		chk(rd, 32'h0000_00a5);
		run(insert_translator_instr, 8'h0, 24'h0, 24'h0, 1'b0);
		chk(gw[0], gr_wr_t'{1'b1, 4'h9, 32'ha500_0000, 1'b1});
		chk(gw[1], gr_wr_t'{1'b1, 4'h3, 32'h1234_5678, 1'b0});
		chk(cyc, 3);
	endtask : t_insert

	task automatic t_wait;
		run(timed_wait_instr, 8'h00, 24'h0, 24'h0, 1'b0);
		chk(cyc, 1);
		int_other_pending <= 1'b1;
		run(timed_wait_instr, 8'h03, 24'h0, 24'h0, 1'b0);
		int_other_pending <= 1'b0;
		chk(exc, exc_intr);
		chk(cyc inside {[99:103]}, 1'b1);
		fork
			run(timed_wait_instr, 8'h01, 24'h0, 24'h0, 1'b0);
			begin
				repeat (250) @(posedge clk_sys);
				int_timer_pending <= 1'b1;
				repeat (150) @(posedge clk_sys);
				int_timer_pending <= 1'b0;
			end
		join
		chk(services > 0, 1'b1);
		chk(exc, exc_none);
		chk(cyc inside {[25599:25603]}, 1'b1);
	endtask : t_wait

	task automatic t_base;
		for (int i = 0; i < 2; i++)
		begin
			run(i ? load_pref_base_instr : store_pref_base_instr, 8'h0, 24'h100, 24'h0, 1'b1);
			chk(exc, exc_priv);
			run(i ? load_pref_base_instr : store_pref_base_instr, 8'h0, 24'h102, 24'h0, 1'b0);
			chk(exc, exc_spec);
		end
		bus_wr(8'h54, 32'h0000_000a);
		storage_model_inst.mem[32] = {32'h0028_1f00, 32'h0};
		storage_model_inst.mem[33] = {32'h0008_1000, 32'h0};
		run(load_pref_base_instr, 8'h0, 24'h100, 24'h0, 1'b0);
		chk(last_addr, 24'h50_1000);
		bus_rd(8'h08);
		chk(rd, 32'h0000_281a);
		bad_addr <= 24'h08_1000;
		run(load_pref_base_instr, 8'h0, 24'h108, 24'h0, 1'b0);
		chk(exc, exc_spec);
		bus_rd(8'h08);
		chk(rd, 32'h0000_281a);
		slow <= 1'b1;
		run(store_pref_base_instr, 8'h0, 24'h104, 24'h0, 1'b0);
		chk(ascs, 1);
		chk(last_mark, 8'h0f);
		chk(storage_model_inst.mem[32], {32'h0028_1f00, 32'h0028_100a});
		slow <= 1'b0;
	endtask : t_base

	task automatic t_copy;
		storage_model_inst.mem[64] = 64'h1111_1111_2222_2222;
		storage_model_inst.mem[65] = 64'h3333_3333_4444_4444;
		storage_model_inst.mem[97] = 64'h5555_5555_6666_6666;
		storage_model_inst.mem[128] = 64'h7777_7777_7777_7777;
		run(word_copy_instr, 8'h02, 24'h300, 24'h200, 1'b0);
		chk(storage_model_inst.mem[96], 64'h1111_1111_2222_2222);
		chk(storage_model_inst.mem[97], 64'h3333_3333_6666_6666);
		run(word_copy_instr, 8'h00, 24'h400, 24'h200, 1'b0);
		chk(storage_model_inst.mem[128], 64'h1111_1111_7777_7777);
		r0 = reads;
		run(word_copy_instr, 8'h00, 24'h300, 24'h202, 1'b0);
		chk(exc, exc_spec);
		chk(reads - r0, 8'h1);
		r0 = reads;
		run(word_copy_instr, 8'h03, 24'h208, 24'h200, 1'b0);
		chk(reads - r0, 8'h1);
		chk(storage_model_inst.mem[66], 64'h1111_1111_2222_2222);
		bus_rd(8'h0c);
		chk(rd[4], 1'b1);
		bad_addr <= 24'h00_0500;
		run(word_copy_instr, 8'h00, 24'h500, 24'h200, 1'b0);
		chk(exc, exc_prot);
		run(word_copy_instr, 8'h00, 24'h304, 24'h200, 1'b0);
		chk(exc, exc_unsup);
		run(word_copy_instr, 8'h00, 24'h300, 24'h80_0200, 1'b0);
		chk(exc, exc_addr);
	endtask : t_copy

	// free-running clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// reset, then each scenario in turn
	initial
	begin
		reset = 1'b1;
		instr = '0;
		bus = '0;
		int_other_pending = 1'b0;
		int_timer_pending = 1'b0;
		slow = 1'b0;
		bad_addr = 24'hff_ffff;
		errors = 0;
		comparisons = 0;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_insert();
		t_wait();
		t_base();
		t_copy();
		conclude();
	end
endmodule : tb_multi_element_instr_exec

`default_nettype wire
